// >>> design/qse_pkg.sv
// Package for the questionable status and error queue block
package qse_pkg;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] QSE_ADR_COND = 8'h00;
	localparam logic [7:0] QSE_ADR_EVENT = 8'h04;
	localparam logic [7:0] QSE_ADR_ENABLE = 8'h08;
	localparam logic [7:0] QSE_ADR_PTR = 8'h0C;
	localparam logic [7:0] QSE_ADR_NTR = 8'h10;
	localparam logic [7:0] QSE_ADR_ERRQ = 8'h14;
	localparam logic [7:0] QSE_ADR_ERRCNT = 8'h18;
	localparam logic [7:0] QSE_ADR_VERSION = 8'h1C;
	localparam logic [7:0] QSE_ADR_CTRL = 8'h20;
	localparam logic [7:0] QSE_ADR_STB = 8'h24;

	// ****************************************
	// Fields and values
	// ****************************************
	localparam int QSE_BIT_OVERVOLT = 0;
	localparam int QSE_BIT_OVERCURR = 1;
	localparam int QSE_BIT_OVERTEMP = 4;
	localparam int QSE_BIT_INHIBIT = 9;
	localparam int QSE_BIT_UNREG = 10;
	localparam int QSE_BIT_SUMMARY = 3;
	localparam int QSE_BIT_PRESET = 0;
	localparam int QSE_BIT_CLS = 1;
	localparam logic [15:0] QSE_DEFINED = 16'h0613;
	localparam logic [15:0] QSE_PTR_PRESET = 16'h0613;
	localparam logic [15:0] QSE_MASK_MAX = 16'h7FD7;
	localparam logic [15:0] QSE_ENABLE_RST = 16'h0000;
	localparam logic [15:0] QSE_FILTER_RST = 16'h0000;
	localparam logic [15:0] QSE_ERR_NONE = 16'h0000;
	localparam logic [15:0] QSE_ERR_OVF = 16'hFEA2;
	localparam logic [15:0] QSE_MSG_NONE = 16'h0000;
	localparam logic [15:0] QSE_MSG_OVF = 16'h0001;

	typedef struct packed {
		logic overvoltage_trip;
		logic overcurrent_trip;
		logic overtemperature_flag;
		logic remote_inhibit_flag;
		logic output_unregulated_flag;
	} qse_fault_type;

	typedef struct packed {
		logic [15:0] msg;
		logic signed [15:0] code;
	} qse_err_type;

endpackage : qse_pkg

// >>> design/qse_status_block.sv
// Questionable status group, error queue and version, Wishbone slave
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
module qse_status_block #(
	parameter int ERR_DEPTH = 8,
	parameter logic [15:0] VERSION_YEAR = 16'h07D0,
	parameter logic [15:0] VERSION_REV = 16'h0000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire qse_pkg::qse_fault_type fault_i,
	input wire logic err_push_i,
	input wire qse_pkg::qse_err_type err_i,
	output logic ques_summary_o
);

	localparam int PW = $clog2(ERR_DEPTH);
	localparam int CW = $clog2(ERR_DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(ERR_DEPTH);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic mask_ok(input logic [31:0] d);
		mask_ok = (d[31:16] == 16'h0000) && (d[15:0] <= qse_pkg::QSE_MASK_MAX);
	endfunction : mask_ok

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	// ****************************************
	// Bus decode
	// ****************************************
	logic take_w;
	logic wr_w;
	logic rd_w;
	logic full_sel_w;
	assign take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign full_sel_w = wb_sel_i[1] & wb_sel_i[0];
	assign wr_w = take_w & wb_we_i & full_sel_w;
	assign rd_w = take_w & ~wb_we_i;

	logic wr_enable_w;
	logic wr_ptr_w;
	logic wr_ntr_w;
	logic preset_w;
	logic cls_w;
	logic rd_event_w;
	logic rd_err_w;
	assign wr_enable_w = wr_w & hit(wb_adr_i, qse_pkg::QSE_ADR_ENABLE)
		& mask_ok(wb_dat_i);
	assign wr_ptr_w = wr_w & hit(wb_adr_i, qse_pkg::QSE_ADR_PTR)
		& mask_ok(wb_dat_i);
	assign wr_ntr_w = wr_w & hit(wb_adr_i, qse_pkg::QSE_ADR_NTR)
		& mask_ok(wb_dat_i);
	assign preset_w = wr_w & hit(wb_adr_i, qse_pkg::QSE_ADR_CTRL)
		& wb_dat_i[qse_pkg::QSE_BIT_PRESET];
	assign cls_w = wr_w & hit(wb_adr_i, qse_pkg::QSE_ADR_CTRL)
		& wb_dat_i[qse_pkg::QSE_BIT_CLS];
	assign rd_event_w = rd_w & hit(wb_adr_i, qse_pkg::QSE_ADR_EVENT);
	assign rd_err_w = rd_w & hit(wb_adr_i, qse_pkg::QSE_ADR_ERRQ);

	// ****************************************
	// Fault pin synchronisers and condition
	// ****************************************
	qse_pkg::qse_fault_type sync1_r;
	qse_pkg::qse_fault_type sync2_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= fault_i;
			sync2_r <= sync1_r;
		end
	end

	logic [15:0] cond_w;
	always_comb begin
		cond_w = 16'h0000;
		cond_w[qse_pkg::QSE_BIT_OVERVOLT] = sync2_r.overvoltage_trip;
		cond_w[qse_pkg::QSE_BIT_OVERCURR] = sync2_r.overcurrent_trip;
		cond_w[qse_pkg::QSE_BIT_OVERTEMP] = sync2_r.overtemperature_flag;
		cond_w[qse_pkg::QSE_BIT_INHIBIT] = sync2_r.remote_inhibit_flag;
		cond_w[qse_pkg::QSE_BIT_UNREG] = sync2_r.output_unregulated_flag;
	end

	logic [15:0] cond_prev_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cond_prev_r <= 16'h0000;
		end else begin
			cond_prev_r <= cond_w;
		end
	end

	// ****************************************
	// Enable mask and transition filters
	// ****************************************
	logic [15:0] enable_r;
	logic [15:0] ptr_r;
	logic [15:0] ntr_r;
	logic [15:0] ptr_nxt;
	logic [15:0] ntr_nxt;
	always_comb begin
		ptr_nxt = ptr_r;
		ntr_nxt = ntr_r;
		if (wr_ptr_w) begin
			ptr_nxt = wb_dat_i[15:0];
		end
		if (wr_ntr_w) begin
			ntr_nxt = wb_dat_i[15:0];
		end
		if (preset_w) begin
			ptr_nxt = qse_pkg::QSE_PTR_PRESET;
			ntr_nxt = qse_pkg::QSE_FILTER_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_r <= qse_pkg::QSE_FILTER_RST;
			ntr_r <= qse_pkg::QSE_FILTER_RST;
		end else begin
			ptr_r <= ptr_nxt;
			ntr_r <= ntr_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_r <= qse_pkg::QSE_ENABLE_RST;
		end else if (preset_w) begin
			enable_r <= qse_pkg::QSE_ENABLE_RST;
		end else if (wr_enable_w) begin
			enable_r <= wb_dat_i[15:0];
		end
	end

	// ****************************************
	// Event register
	// ****************************************
	// Newly enabled filter bits act as if the edge just happened
	logic [15:0] set_w;
	logic [15:0] event_r;
	logic [15:0] event_nxt;
	always_comb begin
		set_w = (ptr_r & cond_w & ~cond_prev_r)
			| (ntr_r & ~cond_w & cond_prev_r);
		set_w = set_w | (ptr_nxt & ~ptr_r & cond_w)
			| (ntr_nxt & ~ntr_r & ~cond_w);
		set_w = set_w & qse_pkg::QSE_DEFINED;
		event_nxt = event_r;
		if (rd_event_w || cls_w) begin
			event_nxt = 16'h0000;
		end
		event_nxt = event_nxt | set_w;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_r <= 16'h0000;
		end else begin
			event_r <= event_nxt;
		end
	end

	// Lags an enable write by one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ques_summary_o <= 1'b0;
		end else begin
			ques_summary_o <= |(event_nxt & enable_r);
		end
	end

	// ****************************************
	// Error queue
	// ****************************************
	qse_pkg::qse_err_type mem_r [ERR_DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic ovf_r;
	logic pop_w;
	logic push_w;
	logic ovf_wr_w;
	assign pop_w = rd_err_w & (count_r != '0) & ~cls_w;
	assign push_w = err_push_i & ((count_r != FULL) | pop_w | cls_w);
	// Once the overflow marker is in, further errors are dropped
	assign ovf_wr_w = err_push_i & ~push_w & ~ovf_r;

	always_ff @(posedge clk_i) begin
		if (push_w) begin
			mem_r[cls_w ? '0 : wr_ptr_r] <= err_i;
		end else if (ovf_wr_w) begin
			mem_r[wr_ptr_r - 1'b1] <= '{msg: qse_pkg::QSE_MSG_OVF,
				code: qse_pkg::QSE_ERR_OVF};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else if (cls_w) begin
			wr_ptr_r <= PW'(push_w);
			rd_ptr_r <= '0;
			count_r <= CW'(push_w);
		end else begin
			if (push_w) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop_w) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + CW'(push_w) - CW'(pop_w);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || cls_w || pop_w) begin
			ovf_r <= 1'b0;
		end else if (ovf_wr_w) begin
			ovf_r <= 1'b1;
		end
	end

	// ****************************************
	// Read mux and acknowledge
	// ****************************************
	logic [31:0] rdata_w;
	always_comb begin
		rdata_w = 32'h0000_0000;
		case (wb_adr_i)
			qse_pkg::QSE_ADR_COND: rdata_w[15:0] = cond_w;
			qse_pkg::QSE_ADR_EVENT: rdata_w[15:0] = event_r;
			qse_pkg::QSE_ADR_ENABLE: rdata_w[15:0] = enable_r;
			qse_pkg::QSE_ADR_PTR: rdata_w[15:0] = ptr_r;
			qse_pkg::QSE_ADR_NTR: rdata_w[15:0] = ntr_r;
			qse_pkg::QSE_ADR_ERRQ: begin
				if (count_r == '0) begin
					rdata_w = {qse_pkg::QSE_MSG_NONE,
						qse_pkg::QSE_ERR_NONE};
				end else begin
					rdata_w = mem_r[rd_ptr_r];
				end
			end
			qse_pkg::QSE_ADR_ERRCNT: rdata_w[CW-1:0] = count_r;
			qse_pkg::QSE_ADR_VERSION: begin
				rdata_w = {VERSION_YEAR, VERSION_REV};
			end
			qse_pkg::QSE_ADR_STB: begin
				rdata_w[qse_pkg::QSE_BIT_SUMMARY] = ques_summary_o;
			end
			default: rdata_w = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= take_w;
			if (rd_w) begin
				wb_dat_o <= rdata_w;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_EVENT_HOLD: assert property (
		!(rd_event_w || cls_w) |=> (($past(event_r) & ~event_r) == 16'h0000))
		else $error("event bit lost without clear");

	AST_EVENT_READ: assert property (
		rd_event_w |=> (wb_dat_o[15:0] == $past(event_r))
			&& (event_r == $past(set_w)))
		else $error("event read did not return and clear");

	AST_COND_LIVE: assert property (
		fault_i.remote_inhibit_flag [*3] |-> cond_w[qse_pkg::QSE_BIT_INHIBIT])
		else $error("condition does not follow fault pin");

	AST_SUMMARY: assert property (
		$stable(enable_r) |-> (ques_summary_o == |(event_r & enable_r)))
		else $error("summary bit mismatch");

	AST_ENABLE_WR: assert property (
		wr_enable_w && !preset_w |=> enable_r == $past(wb_dat_i[15:0])
			&& enable_r <= qse_pkg::QSE_MASK_MAX)
		else $error("enable write not stored");

	AST_NEG_EDGE: assert property (
		1'b1 |=> (($past(ntr_r & ~cond_w & cond_prev_r & qse_pkg::QSE_DEFINED)
			& ~event_r) == 16'h0000))
		else $error("falling edge event missed");

	AST_POS_EDGE: assert property (
		1'b1 |=> (($past(ptr_r & cond_w & ~cond_prev_r) & ~event_r) == 16'h0000))
		else $error("rising edge event missed");

	AST_FILTER_WR: assert property (
		wr_ptr_w |=> (($past(wb_dat_i[15:0] & ~ptr_r & cond_w)
			& qse_pkg::QSE_DEFINED & ~event_r) == 16'h0000))
		else $error("filter write did not raise event");

	AST_ERR_EMPTY: assert property (
		rd_err_w && count_r == '0 |=> wb_dat_o == 32'h0000_0000)
		else $error("empty queue answer wrong");

	AST_ERR_POP: assert property (
		pop_w && !push_w |=> count_r == $past(count_r) - 1'b1)
		else $error("error read did not pop");

	AST_ERR_OVF: assert property (
		ovf_wr_w |=> ovf_r ##0 (mem_r[wr_ptr_r - 1'b1].code
			== qse_pkg::QSE_ERR_OVF) && count_r == FULL)
		else $error("overflow marker missing");

	AST_PRESET: assert property (
		preset_w |=> ptr_r == qse_pkg::QSE_PTR_PRESET && ntr_r == 16'h0000
			&& enable_r == 16'h0000)
		else $error("preset values wrong");

	AST_CLS: assert property (
		cls_w && !err_push_i |=> count_r == '0
			&& ($stable(enable_r) || $past(preset_w))
			&& event_r == $past(set_w))
		else $error("clear status incomplete");

endmodule : qse_status_block

// >>> verification/qse_host_model.sv
// Wishbone master model standing in for the remote controller
`timescale 1ns/1ns
module qse_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o,
	output logic [3:0] sel_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		dat_o = 32'h00000000;
		sel_o = 4'hF;
	end

	// ****************************************
	// One classic cycle, held until ack
	// ****************************************
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Stale data inverted so nothing leans on it
		dat_o <= ~d;
	endtask : xfer
endmodule : qse_host_model

// >>> verification/testbench.sv
// Self-checking testbench for the questionable status block
`timescale 1ns/1ns
module testbench;
	logic clk_i;
	logic rst_i;
	logic cyc, stb, we, ack, summary, err_push;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0] sel;
	qse_pkg::qse_fault_type fault;
	qse_pkg::qse_err_type err;
	int err_total;
	int n_compared;

	qse_status_block qse_status_block_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fault_i(fault), .err_push_i(err_push), .err_i(err),
		.ques_summary_o(summary));
	qse_host_model qse_host_model_i (.clk_i(clk_i), .ack_i(ack),
		.dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.dat_o(wdat), .sel_o(sel));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task test_done;
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		qse_host_model_i.xfer(1'b1, a, d, q);
	endtask : wr

	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		qse_host_model_i.xfer(1'b0, a, 32'h00000000, q);
		chk(nm, e, q);
	endtask : rc

	// Two sync stages plus the edge compare
	task set_fault(input logic [4:0] v);
		@(posedge clk_i);
		fault <= v;
		repeat (4) @(posedge clk_i);
	endtask : set_fault

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		rc("enable", qse_pkg::QSE_ADR_ENABLE, 32'h00000000);
		rc("ptr", qse_pkg::QSE_ADR_PTR, 32'h00000000);
		rc("ntr", qse_pkg::QSE_ADR_NTR, 32'h00000000);
		rc("event", qse_pkg::QSE_ADR_EVENT, 32'h00000000);
		rc("errq", qse_pkg::QSE_ADR_ERRQ, 32'h00000000);
		rc("version", qse_pkg::QSE_ADR_VERSION, 32'h07D00000);
		rc("unmapped", 8'h28, 32'h00000000);
	endtask : t_reset

	task t_limits;
		wr(qse_pkg::QSE_ADR_ENABLE, 32'h00007FD7);
		wr(qse_pkg::QSE_ADR_ENABLE, 32'h00007FD8);
		rc("enable max", qse_pkg::QSE_ADR_ENABLE, 32'h00007FD7);
		wr(qse_pkg::QSE_ADR_ENABLE, 32'h00000000);
		wr(qse_pkg::QSE_ADR_NTR, 32'h00007FD8);
		rc("ntr max", qse_pkg::QSE_ADR_NTR, 32'h00000000);
	endtask : t_limits

	task t_edges;
		wr(qse_pkg::QSE_ADR_PTR, 32'h00000001);
		wr(qse_pkg::QSE_ADR_NTR, 32'h00000010);
		rc("ntr write event", qse_pkg::QSE_ADR_EVENT, 32'h00000010);
		rc("event cleared", qse_pkg::QSE_ADR_EVENT, 32'h00000000);
		set_fault(5'b10100);
		rc("cond", qse_pkg::QSE_ADR_COND, 32'h00000011);
		rc("rise event", qse_pkg::QSE_ADR_EVENT, 32'h00000001);
		set_fault(5'b00000);
		rc("fall event", qse_pkg::QSE_ADR_EVENT, 32'h00000010);
		set_fault(5'b11111);
		rc("cond all", qse_pkg::QSE_ADR_COND, 32'h00000613);
		set_fault(5'b00000);
		rc("event any", qse_pkg::QSE_ADR_EVENT, 32'h00000011);
	endtask : t_edges

	task t_summary;
		wr(qse_pkg::QSE_ADR_ENABLE, 32'h00000001);
		set_fault(5'b10000);
		chk("summary set", 32'h1, {31'h0, summary});
		rc("stb", qse_pkg::QSE_ADR_STB, 32'h00000008);
		rc("event", qse_pkg::QSE_ADR_EVENT, 32'h00000001);
		repeat (2) @(posedge clk_i);
		chk("summary clear", 32'h0, {31'h0, summary});
	endtask : t_summary

	task t_preset;
		set_fault(5'b00100);
		rc("event pre", qse_pkg::QSE_ADR_EVENT, 32'h00000000);
		wr(qse_pkg::QSE_ADR_CTRL, 32'h00000001);
		rc("ptr", qse_pkg::QSE_ADR_PTR, 32'h00000613);
		rc("ntr", qse_pkg::QSE_ADR_NTR, 32'h00000000);
		rc("enable", qse_pkg::QSE_ADR_ENABLE, 32'h00000000);
		rc("preset event", qse_pkg::QSE_ADR_EVENT, 32'h00000010);
		set_fault(5'b00000);
	endtask : t_preset

	task t_errq;
		for (int i = 1; i <= 9; i++) begin
			@(posedge clk_i);
			err_push <= 1'b1;
			err <= {16'(i), 16'h0000 - 16'(i)};
		end
		@(posedge clk_i);
		err_push <= 1'b0;
		rc("errcnt", qse_pkg::QSE_ADR_ERRCNT, 32'h00000008);
		for (int i = 1; i <= 7; i++)
			rc("errq", qse_pkg::QSE_ADR_ERRQ, {16'(i), 16'h0000 - 16'(i)});
		rc("errq ovf", qse_pkg::QSE_ADR_ERRQ, 32'h0001FEA2);
		rc("errq empty", qse_pkg::QSE_ADR_ERRQ, 32'h00000000);
		@(posedge clk_i);
		err_push <= 1'b1;
		@(posedge clk_i);
		err_push <= 1'b0;
		wr(qse_pkg::QSE_ADR_ENABLE, 32'h00000010);
		set_fault(5'b00100);
		wr(qse_pkg::QSE_ADR_CTRL, 32'h00000002);
		rc("errq cls", qse_pkg::QSE_ADR_ERRQ, 32'h00000000);
		rc("event cls", qse_pkg::QSE_ADR_EVENT, 32'h00000000);
		rc("enable kept", qse_pkg::QSE_ADR_ENABLE, 32'h00000010);
		rc("ptr kept", qse_pkg::QSE_ADR_PTR, 32'h00000613);
		wr(qse_pkg::QSE_ADR_CTRL, 32'h00000003);
		rc("enable both", qse_pkg::QSE_ADR_ENABLE, 32'h00000000);
	endtask : t_errq

	initial begin
		repeat (6000) @(posedge clk_i);
		err_total++;
		test_done();
	end

	initial begin
		err_total = 0;
		n_compared = 0;
		rst_i = 1'b1;
		err_push = 1'b0;
		fault = '0;
		err = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_limits();
		t_edges();
		t_summary();
		t_preset();
		t_errq();
		test_done();
	end
endmodule : testbench
